// *** pkg/flip_pkg.sv ***
// Notes on behaviour
// - Upper and lower priority bits form level 0 (00) up to level 3 (11).
// - Grant a pending enabled request only if no equal or higher level in service.
// - Hold a request pending while an equal or higher level is in service.
// - Higher level preempts lower service; lower service resumes after the higher completes.
// - With the counter array present, seven sources each take one of four levels.
// - Without the counter array, six sources with the same four-level scheme.
// - Enable, lower priority and upper priority registers are software visible.
// - Upper priority register sits at B7H and pairs with the matching lower bits.
// - Enable bit 7 clear blocks all; set lets each source follow its own enable.
// - Enable at A8H: ext0 b0, timer0 b1, ext1 b2, timer1 b3, uart b4, timer2 b5.
// - Enable bit 6 serves the counter array only where present; otherwise unimplemented.
package flip_pkg;

  localparam int NUM_SRC = 7;
  localparam int NUM_LEVEL = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_ENABLE = 8'ha8;
  localparam logic [7:0] ADDR_PRIO_LOW = 8'hb8;
  localparam logic [7:0] ADDR_PRIO_UPPER = 8'hb7;
  localparam logic [7:0] ADDR_STATUS = 8'hb0;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int COUNTER_EN_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////////
  // Sources in polling order: ext0, timer0, ext1, timer1, counter array, uart, timer2
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_COUNTER = 4;
  localparam logic [2:0] SRC_BIT [NUM_SRC] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h4, 3'h5};
  localparam logic [7:0] SRC_VECTOR [NUM_SRC] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h33, 8'h23, 8'h2b};
  localparam logic [NUM_SRC-1:0] HW_CLEAR_ALWAYS = 7'h0a;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } flip_bus_t;

  typedef struct packed {
    logic valid;
    logic [1:0] level;
    logic [2:0] source;
    logic [7:0] vector;
  } flip_grant_t;

endpackage : flip_pkg

// *** hw/flip_top.sv ***
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
module flip_top #(
  parameter int HAS_COUNTER_ARRAY = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire flip_pkg::flip_bus_t bus,
  output logic [7:0] rdata,
  input wire logic [flip_pkg::NUM_SRC-1:0] src_request,
  input wire logic ext0_edge_mode,
  input wire logic ext1_edge_mode,
  input wire logic vector_taken,
  input wire logic service_done,
  output flip_pkg::flip_grant_t grant,
  output logic [flip_pkg::NUM_SRC-1:0] hw_flag_clear
);

  if (HAS_COUNTER_ARRAY != 0 && HAS_COUNTER_ARRAY != 1) begin : g_bad_param
    $error("HAS_COUNTER_ARRAY must be 0 or 1");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] interrupt_enable_bits;
  logic [7:0] priority_low_select;
  logic [7:0] priority_upper_select;
  logic [flip_pkg::NUM_LEVEL-1:0] in_service;

  wire sel_enable = bus.addr == flip_pkg::ADDR_ENABLE;
  wire sel_low = bus.addr == flip_pkg::ADDR_PRIO_LOW;
  wire sel_upper = bus.addr == flip_pkg::ADDR_PRIO_UPPER;
  wire sel_status = bus.addr == flip_pkg::ADDR_STATUS;

  // Bit 6 is not stored at all without the counter array, so it always reads zero
  wire [7:0] enable_mask = (HAS_COUNTER_ARRAY == 1) ? 8'hff : 8'hbf;
  wire [7:0] next_enable = bus.wdata & enable_mask;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_enable_bits <= flip_pkg::ENABLE_RESET;
      priority_low_select <= flip_pkg::PRIO_RESET;
      priority_upper_select <= flip_pkg::PRIO_RESET;
    end else if (bus.we) begin
      if (sel_enable) begin
        interrupt_enable_bits <= next_enable;
      end
      if (sel_low) begin
        priority_low_select <= bus.wdata & enable_mask;
      end
      if (sel_upper) begin
        priority_upper_select <= bus.wdata & enable_mask;
      end
    end
  end

  wire [7:0] status_word = {3'h0, grant.valid, in_service};
  wire [7:0] read_mux = sel_enable ? interrupt_enable_bits :
                        sel_low ? priority_low_select :
                        sel_upper ? priority_upper_select :
                        sel_status ? status_word : flip_pkg::READ_IDLE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= flip_pkg::READ_IDLE;
    end else begin
      rdata <= bus.re ? read_mux : flip_pkg::READ_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-source level and eligibility
  wire global_irq_enable = interrupt_enable_bits[flip_pkg::GLOBAL_EN_BIT];
  logic [1:0] src_level [flip_pkg::NUM_SRC];
  logic [flip_pkg::NUM_SRC-1:0] src_active;

  for (genvar s = 0; s < flip_pkg::NUM_SRC; s++) begin : g_src
    localparam logic [2:0] BITPOS = flip_pkg::SRC_BIT[s];
    localparam bit PRESENT = (s != flip_pkg::SRC_COUNTER) || (HAS_COUNTER_ARRAY == 1);
    assign src_level[s] = {priority_upper_select[BITPOS], priority_low_select[BITPOS]};
    assign src_active[s] = PRESENT && global_irq_enable && interrupt_enable_bits[BITPOS]
                           && src_request[s];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Arbitration: highest level first, then first in polling order
  logic cand_found;
  logic [1:0] cand_level;
  logic [2:0] cand_source;

  always_comb begin
    cand_found = 1'b0;
    cand_level = 2'h0;
    cand_source = 3'h0;
    for (int lv = flip_pkg::NUM_LEVEL - 1; lv >= 0; lv--) begin
      for (int s = 0; s < flip_pkg::NUM_SRC; s++) begin
        if (!cand_found && src_active[s] && src_level[s] == lv[1:0]) begin
          cand_found = 1'b1;
          cand_level = lv[1:0];
          cand_source = s[2:0];
        end
      end
    end
  end

  // Any service at the candidate's level or above blocks it
  wire [3:0] level_ge_mask = 4'hf << cand_level;
  wire cand_blocked = |(in_service & level_ge_mask);
  // Drop the request in the acknowledge cycle so it is not offered twice
  wire next_valid = cand_found && !cand_blocked && !(vector_taken && grant.valid);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      grant <= '0;
    end else begin
      grant.valid <= next_valid;
      grant.level <= cand_level;
      grant.source <= cand_source;
      grant.vector <= flip_pkg::SRC_VECTOR[cand_source];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // In-service stack: one bit per level, the highest set bit is the running routine
  wire taken = vector_taken && grant.valid;
  wire [3:0] take_onehot = taken ? (4'h1 << grant.level) : 4'h0;
  wire [3:0] top_onehot = in_service[3] ? 4'h8 :
                          in_service[2] ? 4'h4 :
                          in_service[1] ? 4'h2 :
                          in_service[0] ? 4'h1 : 4'h0;
  wire [3:0] done_mask = service_done ? top_onehot : 4'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_service <= 4'h0;
    end else begin
      // Clearing only the top bit lets the preempted lower routine carry on
      in_service <= (in_service & ~done_mask) | take_onehot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Hardware flag clear on vectoring
  logic [flip_pkg::NUM_SRC-1:0] clear_capable;
  always_comb begin
    clear_capable = flip_pkg::HW_CLEAR_ALWAYS;
    clear_capable[flip_pkg::SRC_EXT0] = ext0_edge_mode;
    clear_capable[flip_pkg::SRC_EXT1] = ext1_edge_mode;
  end

  wire [flip_pkg::NUM_SRC-1:0] take_src = taken ? (7'h01 << grant.source) : 7'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hw_flag_clear <= '0;
    end else begin
      hw_flag_clear <= take_src & clear_capable;
    end
  end

endmodule : flip_top

// *** test/flip_core_model.sv ***
`timescale 1ns/100ps
module flip_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire flip_pkg::flip_grant_t grant,
  output logic vector_taken
);
  // Prompt core: takes any offered grant, never two in a row
  always_ff @(posedge clk or posedge rst) begin
    if (rst) vector_taken <= 1'b0;
    else vector_taken <= grant.valid && !vector_taken;
  end
endmodule : flip_core_model

// *** test/flip_chk.sv ***
`timescale 1ns/100ps
module flip_chk (
  input wire logic clk,
  input wire logic rst,
  input wire flip_pkg::flip_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic [flip_pkg::NUM_SRC-1:0] src_request,
  input wire logic vector_taken,
  input wire logic service_done,
  input wire flip_pkg::flip_grant_t grant,
  input wire logic [flip_pkg::NUM_SRC-1:0] hw_flag_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire take = vector_taken && grant.valid;
  read_idle_a: assert property (!$past(bus.re) |-> rdata == 8'h00) else $error("rdata not idle");
  vec_match_a: assert property (grant.valid |-> grant.vector == flip_pkg::SRC_VECTOR[grant.source])
    else $error("wrong vector");
  take_drop_a: assert property (take |=> !grant.valid) else $error("grant kept");
  clr_timer_a: assert property (take && grant.source == 3'h1 |=> hw_flag_clear == 7'h02)
    else $error("no flag clear");
  clr_soft_a: assert property (take && grant.source > 3'h3 |=> hw_flag_clear == 7'h00)
    else $error("flag cleared");
  ea_block_a: assert property (bus.we && bus.addr == 8'ha8 && !bus.wdata[7] |-> ##2 !grant.valid)
    else $error("grant while off");
  top_block_a: assert property (take && grant.level == 2'h3 && !service_done |=> !service_done |=> !grant.valid)
    else $error("top level passed");
  no_req_a: assert property ((src_request == 7'h00) [*2] |=> !grant.valid) else $error("grant no request");
endmodule : flip_chk
bind flip_top flip_chk u_chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .src_request(src_request),
  .vector_taken(vector_taken), .service_done(service_done), .grant(grant), .hw_flag_clear(hw_flag_clear));

// *** test/testbench.sv ***
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; $display("mismatch %0t got %h want %h", $time, (a), (e)); end end
module testbench;
  logic clk = 0;
  logic rst = 1;
  logic done = 0;
  logic vt;
  logic [7:0] rdata;
  logic [7:0] rdata6;
  logic ext1_edge = 1'b0;
  flip_pkg::flip_grant_t grant6;
  logic [6:0] req = '0;
  logic [6:0] clr;
  int fail_count = 0;
  int num_checks = 0;
  flip_pkg::flip_bus_t bus = '0;
  flip_pkg::flip_grant_t grant;
  always #2.5 clk = ~clk;
  flip_top dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .src_request(req), .ext0_edge_mode(1'b1),
    .ext1_edge_mode(ext1_edge), .vector_taken(vt), .service_done(done), .grant(grant), .hw_flag_clear(clr));
  // Six-source variant: never acknowledged, only its registers and grant are judged
  flip_top #(.HAS_COUNTER_ARRAY(0)) dut6 (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata6), .src_request(req),
    .ext0_edge_mode(1'b1), .ext1_edge_mode(1'b1), .vector_taken(1'b0), .service_done(1'b0), .grant(grant6),
    .hw_flag_clear());
  flip_core_model core (.clk(clk), .rst(rst), .grant(grant), .vector_taken(vt));
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask : wr
  task rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 `CHK(rdata, e)
  endtask : rc
  task fin;
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
  endtask : fin
  // Core accepts on its own, so the grant is judged before it is taken
  task tk(input logic [2:0] s, input logic [1:0] l, input logic [6:0] c);
    for (int n = 0; n < 20 && grant.valid !== 1'b1; n++) @(posedge clk) #1;
    `CHK(grant, {1'b1, l, s, flip_pkg::SRC_VECTOR[s]})
    repeat (2) @(posedge clk);
    req[s] <= 1'b0;
    #1 `CHK(clr, c)
  endtask : tk
  task regs;
    rc(8'ha8, 8'h00);
    wr(8'hb7, 8'h5a);
    rc(8'hb7, 8'h5a);
    wr(8'hb8, 8'h3c);
    rc(8'hb8, 8'h3c);
    rc(8'h10, 8'h00);
    wr(8'ha8, 8'hff);
    rc(8'ha8, 8'hff);
    @(posedge clk) bus <= '{8'ha8, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 `CHK(rdata6, 8'hbf)
    @(posedge clk) req <= 7'h10;
    repeat (4) @(posedge clk);
    #1 `CHK(grant6.valid, 1'b0)
    @(posedge clk) req <= 7'h00;
    fin();
    wr(8'ha8, 8'h00);
  endtask : regs
  task poll;
    wr(8'hb7, 8'h00);
    wr(8'hb8, 8'h00);
    wr(8'ha8, 8'h7f);
    @(posedge clk) req <= 7'h7f;
    repeat (4) @(posedge clk);
    #1 `CHK(grant.valid, 1'b0)
    wr(8'ha8, 8'hff);
    for (int i = 0; i < 7; i++) begin
      // Ext1 runs level-triggered here, so its flag stays for software
      tk(3'(i), 2'h0, (i < 4 && i != 2) ? 7'(1 << i) : 7'h00);
      fin();
    end
  endtask : poll
  task nest;
    wr(8'hb7, 8'h05);
    wr(8'hb8, 8'h06);
    @(posedge clk) req <= 7'h02;
    tk(3'h1, 2'h1, 7'h02);
    @(posedge clk) req <= 7'h01;
    tk(3'h0, 2'h2, 7'h01);
    rc(8'hb0, 8'h06);
    ext1_edge <= 1'b1;
    @(posedge clk) req <= 7'h04;
    tk(3'h2, 2'h3, 7'h04);
    @(posedge clk) req <= 7'h01;
    repeat (4) @(posedge clk);
    #1 `CHK(grant.valid, 1'b0)
    fin();
    repeat (4) @(posedge clk);
    #1 `CHK(grant.valid, 1'b0)
    fin();
    tk(3'h0, 2'h2, 7'h01);
    fin();
    fin();
    rc(8'hb0, 8'h00);
  endtask : nest
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    regs();
    poll();
    nest();
    print_verdict();
  end
  initial begin
    #20000;
    fail_count++;
    print_verdict();
  end
endmodule : testbench
